// ==== mocd_pkg.sv ====
// constants and types for the media object command decoder
// Overview of operation
// - sync bit holds dispatch for spawn message
// - scoreboard bit clear bypasses scoreboard fields
// - half-slice field: 10b hs1, 01b hs0, 00b any
// - indirect length in bytes; zero disables fetch
// - start address byte offset, top bits zero
// - scoreboard y/x from dword four fields
// - four-bit color from dword five
// - command mask anded with state mask
// - inline dwords passed through unchanged
// - persistent command recognised by header codes
// - six-bit descriptor offset selects descriptor
// - no children: dereference at dispatch ack
// - children: forward handle, dereference on message
// - fence raised after persistent dispatch if needed
// - fence raised again on re-dispatch if needed
// - fence position: queue end or front-end entry
package mocd_pkg;
    localparam logic [2:0] CMD_TYPE_PIPE = 3'h3;
    localparam logic [1:0] CMD_PIPE_MEDIA = 2'h2;
    localparam logic [2:0] CMD_OPC_MEDIA = 3'h1;
    localparam logic [7:0] SUBOPC_OBJECT = 8'h00;
    localparam logic [7:0] SUBOPC_PERSIST = 8'h02;
    localparam int TYPE_HI = 31;
    localparam int TYPE_LO = 29;
    localparam int PIPE_HI = 28;
    localparam int PIPE_LO = 27;
    localparam int OPC_HI = 26;
    localparam int OPC_LO = 24;
    localparam int SUB_HI = 23;
    localparam int SUB_LO = 16;
    localparam int DESC_HI = 5;
    localparam int CHILD_BIT = 31;
    localparam int SYNC_BIT = 24;
    localparam int FENCE_BIT = 23;
    localparam int FTYPE_BIT = 22;
    localparam int SB_USE_BIT = 21;
    localparam int HS_HI = 18;
    localparam int HS_LO = 17;
    localparam int ILEN_HI = 16;
    localparam int ADDR_TOP_LO = 29;
    localparam int SBY_HI = 24;
    localparam int SBY_LO = 16;
    localparam int SBX_HI = 8;
    localparam int COLOR_HI = 19;
    localparam int COLOR_LO = 16;
    localparam int MASK_HI = 7;
    localparam int INLINE_FIRST = 6;
    localparam int PERSIST_DWORDS = 16;
    localparam logic [1:0] HS_ANY = 2'h0;
    localparam logic [1:0] HS_ZERO = 2'h1;
    localparam logic [1:0] HS_ONE = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_BODY = 4'h2,
        ST_WAIT = 4'h4,
        ST_HOLD = 4'h8
    } mocd_state_t;

    // header check used by both command kinds
    function automatic logic mocd_is_media(input logic [31:0] dw, input logic [7:0] sub);
        mocd_is_media = dw[TYPE_HI:TYPE_LO] == CMD_TYPE_PIPE
            && dw[PIPE_HI:PIPE_LO] == CMD_PIPE_MEDIA
            && dw[OPC_HI:OPC_LO] == CMD_OPC_MEDIA
            && dw[SUB_HI:SUB_LO] == sub;
    endfunction
endpackage

// ==== mocd_dw_if.sv ====
// dword stream carrier between the parser and the field extractor
`timescale 1ns/1ps
`default_nettype none
interface mocd_dw_if;
    logic valid;
    logic [31:0] data;
    logic [7:0] index;
    modport src(output valid, output data, output index);
    modport dst(input valid, input data, input index);
endinterface
`default_nettype wire

// ==== mocd_fields.sv ====
// field latch for the fixed dwords of the media object commands
`timescale 1ns/1ps
`default_nettype none
module mocd_fields
    import mocd_pkg::*;
(
    input wire logic ref_clk, // pipeline clock
    input wire logic nrst, // async reset, active low
    mocd_dw_if.dst dw, // incoming dwords
    input wire logic persist, // current command is persistent kind
    output logic [5:0] desc_off, // descriptor offset
    output logic children, // children present
    output logic sync, // thread sync
    output logic sb_use, // scoreboard in use
    output logic [1:0] hs_sel, // half-slice select
    output logic [16:0] ind_len, // indirect length bytes
    output logic [28:0] ind_addr, // indirect start offset
    output logic fence_need, // fence requested
    output logic fence_pos, // fence position
    output logic [8:0] sb_y, // scoreboard y
    output logic [8:0] sb_x, // scoreboard x
    output logic [3:0] sb_color, // dependency color
    output logic [7:0] sb_mask // command mask
);
    typedef struct packed {
        logic [5:0] desc;
        logic child;
        logic sync;
        logic sbu;
        logic [1:0] hs;
        logic [16:0] ilen;
        logic [28:0] iaddr;
        logic fn;
        logic fp;
        logic [8:0] y;
        logic [8:0] x;
        logic [3:0] col;
        logic [7:0] mask;
    } mocd_fld_t;
    mocd_fld_t s_reg, s_next;

    always_comb begin
        s_next = s_reg;
        if (dw.valid) begin
            unique case (dw.index)
                8'h01: s_next.desc = dw.data[DESC_HI:0];
                8'h02: begin
                    s_next.child = dw.data[CHILD_BIT];
                    // persistent kind reads fence bits, object kind reads routing
                    if (persist) begin
                        s_next.fn = dw.data[FENCE_BIT];
                        s_next.fp = dw.data[FTYPE_BIT];
                        s_next.sync = 1'b0;
                        s_next.sbu = 1'b0;
                        s_next.hs = HS_ANY;
                        s_next.ilen = 17'h0;
                    end else begin
                        s_next.fn = 1'b0;
                        s_next.fp = 1'b0;
                        s_next.sync = dw.data[SYNC_BIT];
                        s_next.sbu = dw.data[SB_USE_BIT];
                        s_next.hs = dw.data[HS_HI:HS_LO];
                        s_next.ilen = dw.data[ILEN_HI:0];
                    end
                end
                // offset below 512MB, top bits dropped
                8'h03: s_next.iaddr = persist ? 29'h0 : dw.data[ADDR_TOP_LO-1:0];
                8'h04: begin
                    s_next.y = persist ? 9'h0 : dw.data[SBY_HI:SBY_LO];
                    s_next.x = persist ? 9'h0 : dw.data[SBX_HI:0];
                end
                8'h05: begin
                    s_next.col = persist ? 4'h0 : dw.data[COLOR_HI:COLOR_LO];
                    s_next.mask = persist ? 8'h00 : dw.data[MASK_HI:0];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign desc_off = s_reg.desc;
    assign children = s_reg.child;
    assign sync = s_reg.sync;
    assign sb_use = s_reg.sbu;
    assign hs_sel = s_reg.hs;
    assign ind_len = s_reg.ilen;
    assign ind_addr = s_reg.iaddr;
    assign fence_need = s_reg.fn;
    assign fence_pos = s_reg.fp;
    assign sb_y = s_reg.y;
    assign sb_x = s_reg.x;
    assign sb_color = s_reg.col;
    assign sb_mask = s_reg.mask;
endmodule
`default_nettype wire

// ==== mocd_top.sv ====
// media object command decoder: parser, dispatch gating, handle and fence control
`timescale 1ns/1ps
`default_nettype none
module mocd_top
    import mocd_pkg::*;
#(
    parameter int LEN_W = 16
) (
    input wire logic ref_clk, // pipeline clock
    input wire logic nrst, // async reset, active low
    input wire logic cmd_valid, // command dword valid
    input wire logic [31:0] cmd_data, // command dword
    output logic cmd_ready, // dword accepted
    input wire logic [7:0] state_sb_mask, // mask from front-end state
    input wire logic spawn_root_msg, // spawn-root-thread message
    input wire logic disp_ack, // dispatcher acknowledges dispatch
    input wire logic deref_msg, // root thread dereference message
    input wire logic redispatch, // persistent thread re-dispatched after restore
    input wire logic thread_spawn_msg, // persistent thread sent spawn
    output logic disp_req, // thread dispatch request
    output logic disp_persist, // request is a persistent thread
    output logic [5:0] disp_desc, // descriptor offset
    output logic disp_sb_use, // scoreboard applied
    output logic [8:0] disp_sb_y, // scoreboard y
    output logic [8:0] disp_sb_x, // scoreboard x
    output logic [3:0] disp_color, // dependency color
    output logic [7:0] disp_mask, // effective dependency mask
    output logic disp_hs_any, // dispatcher picks half-slice by load
    output logic disp_hs1, // target half-slice 1 when not any
    output logic ind_fetch, // indirect fetch enabled
    output logic [16:0] ind_len_bytes, // indirect length
    output logic [28:0] ind_start, // indirect start offset
    output logic handle_fwd, // return handle forwarded to thread
    output logic handle_deref, // dereference pulse
    output logic inline_valid, // inline dword valid
    output logic [31:0] inline_data, // inline dword
    output logic fence_queue, // fence at end of root queue
    output logic fence_entry // fence at front-end entry
);
    typedef struct packed {
        mocd_state_t st;
        logic [LEN_W-1:0] left;
        logic [7:0] idx;
        logic persist;
        logic known;
        logic child_live;
        logic req;
        logic prs;
        logic [5:0] desc;
        logic sbu;
        logic [8:0] y;
        logic [8:0] x;
        logic [3:0] col;
        logic [7:0] mask;
        logic hany;
        logic h1;
        logic fetch;
        logic [16:0] ilen;
        logic [28:0] iaddr;
        logic fwd;
        logic deref;
        logic iv;
        logic [31:0] id;
        logic fq;
        logic fe;
        logic fn_live;
        logic fp_live;
    } mocd_top_t;
    mocd_top_t s_reg, s_next;

    mocd_dw_if dwb();
    logic [5:0] f_desc;
    logic f_child, f_sync, f_sbu, f_fn, f_fp;
    logic [1:0] f_hs;
    logic [16:0] f_ilen;
    logic [28:0] f_iaddr;
    logic [8:0] f_y, f_x;
    logic [3:0] f_col;
    logic [7:0] f_mask;
    logic take;

    assign take = cmd_valid && cmd_ready;
    assign dwb.valid = take && s_reg.st == ST_BODY && s_reg.known;
    assign dwb.data = cmd_data;
    assign dwb.index = s_reg.idx;

    mocd_fields u_fields (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .dw(dwb),
        .persist(s_reg.persist),
        .desc_off(f_desc),
        .children(f_child),
        .sync(f_sync),
        .sb_use(f_sbu),
        .hs_sel(f_hs),
        .ind_len(f_ilen),
        .ind_addr(f_iaddr),
        .fence_need(f_fn),
        .fence_pos(f_fp),
        .sb_y(f_y),
        .sb_x(f_x),
        .sb_color(f_col),
        .sb_mask(f_mask)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_next = s_reg;
        s_next.req = 1'b0;
        s_next.deref = 1'b0;
        s_next.iv = 1'b0;
        // spawn clears a fence; any set further down this process wins
        if (thread_spawn_msg) begin
            s_next.fq = 1'b0;
            s_next.fe = 1'b0;
        end
        unique case (s_reg.st)
            ST_IDLE: begin
                if (take && !s_reg.fe) begin
                    // header match; other commands are skipped by length
                    s_next.persist = mocd_is_media(cmd_data, SUBOPC_PERSIST);
                    s_next.known = s_next.persist || mocd_is_media(cmd_data, SUBOPC_OBJECT);
                    // length field excludes two dwords; body counts from dword 1
                    // persistent kind is a fixed sixteen dwords, whatever its length says
                    s_next.left = s_next.persist ? LEN_W'(PERSIST_DWORDS - 1)
                        : LEN_W'(cmd_data[LEN_W-1:0] + 1'b1);
                    s_next.idx = 8'h01;
                    s_next.st = ST_BODY;
                end
            end
            ST_BODY: begin
                if (take) begin
                    // saturate so long inline runs never alias the field dwords
                    s_next.idx = (s_reg.idx == 8'hff) ? 8'hff : s_reg.idx + 8'h01;
                    s_next.left = s_reg.left - 1'b1;
                    if (s_reg.known && (s_reg.idx >= 8'(INLINE_FIRST)
                        || (s_reg.persist && s_reg.idx >= 8'h04))) begin
                        s_next.iv = 1'b1;
                        s_next.id = cmd_data;
                    end
                    if (s_reg.left == LEN_W'(1)) begin
                        s_next.st = s_reg.known ? ST_WAIT : ST_IDLE;
                    end
                end
            end
            ST_WAIT: begin
                if (!f_sync || spawn_root_msg) begin
                    s_next.req = 1'b1;
                    s_next.prs = s_reg.persist;
                    s_next.desc = f_desc;
                    s_next.sbu = f_sbu;
                    s_next.y = f_sbu ? f_y : 9'h0;
                    s_next.x = f_sbu ? f_x : 9'h0;
                    s_next.col = f_sbu ? f_col : 4'h0;
                    s_next.mask = f_sbu ? (f_mask & state_sb_mask) : 8'h00;
                    // half-slice decode; 11b treated as either
                    s_next.hany = f_hs != HS_ZERO && f_hs != HS_ONE;
                    s_next.h1 = f_hs == HS_ONE;
                    // zero length disables fetch and address
                    s_next.fetch = f_ilen != 17'h0;
                    s_next.ilen = f_ilen;
                    s_next.iaddr = (f_ilen != 17'h0) ? f_iaddr : 29'h0;
                    s_next.child_live = f_child;
                    s_next.fn_live = s_reg.persist && f_fn;
                    s_next.fp_live = f_fp;
                    s_next.st = ST_HOLD;
                end
            end
            ST_HOLD: begin
                s_next.req = 1'b1;
                if (disp_ack) begin
                    s_next.req = 1'b0;
                    s_next.st = ST_IDLE;
                    if (!s_reg.child_live) begin
                        s_next.deref = 1'b1;
                    end else begin
                        s_next.fwd = 1'b1;
                    end
                    if (s_reg.fn_live) begin
                        s_next.fq = !s_reg.fp_live;
                        s_next.fe = s_reg.fp_live;
                    end
                end
            end
            default: s_next.st = ST_IDLE;
        endcase
        // forwarded handle: dereference only on the thread's message
        if (s_reg.fwd && deref_msg) begin
            s_next.fwd = 1'b0;
            s_next.deref = 1'b1;
        end
        // re-dispatch after restore raises fence again, set wins
        if (redispatch && s_reg.fn_live) begin
            s_next.fq = !s_reg.fp_live;
            s_next.fe = s_reg.fp_live;
        end
        // queue fence holds the request back inside its own flop
        s_next.req = s_next.req && !s_next.fq;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
            s_reg.st <= ST_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // front-end fence stops intake; queue fence only blocks dispatch
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cmd_ready <= 1'b0;
        end else begin
            cmd_ready <= s_next.st == ST_BODY || (s_next.st == ST_IDLE && !s_next.fe);
        end
    end

    assign disp_req = s_reg.req;
    assign disp_persist = s_reg.prs;
    assign disp_desc = s_reg.desc;
    assign disp_sb_use = s_reg.sbu;
    assign disp_sb_y = s_reg.y;
    assign disp_sb_x = s_reg.x;
    assign disp_color = s_reg.col;
    assign disp_mask = s_reg.mask;
    assign disp_hs_any = s_reg.hany;
    assign disp_hs1 = s_reg.h1;
    assign ind_fetch = s_reg.fetch;
    assign ind_len_bytes = s_reg.ilen;
    assign ind_start = s_reg.iaddr;
    assign handle_fwd = s_reg.fwd;
    assign handle_deref = s_reg.deref;
    assign inline_valid = s_reg.iv;
    assign inline_data = s_reg.id;
    assign fence_queue = s_reg.fq;
    assign fence_entry = s_reg.fe;
endmodule
`default_nettype wire

// ==== mocd_top_properties.sv ====
// concurrent checks on the media object command decoder top ports
`timescale 1ns/1ps
`default_nettype none
module mocd_top_checker (
    input wire logic ref_clk, // clock
    input wire logic nrst, // reset, low
    input wire logic cmd_valid, // dword offered
    input wire logic cmd_ready, // dword taken
    input wire logic [7:0] state_sb_mask, // state mask
    input wire logic disp_ack, // dispatch ack
    input wire logic deref_msg, // release msg
    input wire logic thread_spawn_msg, // fence release
    input wire logic disp_req, // dispatch request
    input wire logic [7:0] disp_mask, // used mask
    input wire logic ind_fetch, // fetch on
    input wire logic [16:0] ind_len_bytes, // fetch length
    input wire logic handle_fwd, // handle forwarded
    input wire logic handle_deref, // release pulse
    input wire logic inline_valid, // inline out
    input wire logic fence_queue, // queue fence
    input wire logic fence_entry // entry fence
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////////////
    chk_mask_and: assert property (disp_req |-> (disp_mask & ~state_sb_mask) == 8'h00)
        else $error("mask outside state mask");
    chk_fetch_len: assert property (disp_req |-> ind_fetch == (ind_len_bytes != 17'h0))
        else $error("fetch enable wrong");
    chk_req_hold: assert property (disp_req && !disp_ack |=> disp_req)
        else $error("request dropped early");
    chk_deref_pulse: assert property (handle_deref |=> !handle_deref)
        else $error("release not a pulse");
    chk_deref_cause: assert property (handle_deref |-> $past(disp_ack) || $past(deref_msg))
        else $error("release without cause");
    chk_fwd_nodrf: assert property (handle_fwd |-> !handle_deref)
        else $error("release while forwarded");
    chk_fwd_cause: assert property ($rose(handle_fwd) |-> $past(disp_ack))
        else $error("forward without ack");
    chk_fence_hold: assert property (fence_entry && !thread_spawn_msg |=> fence_entry)
        else $error("entry fence lost");
    chk_queue_block: assert property (fence_queue |-> !disp_req)
        else $error("dispatch past queue fence");
    chk_entry_block: assert property (fence_entry |-> !cmd_ready)
        else $error("dword taken past fence");
    chk_inline_take: assert property (inline_valid |-> $past(cmd_valid && cmd_ready))
        else $error("inline without dword");
    cover property (disp_req && disp_ack);
    cover property ($rose(fence_entry));
    cover property ($rose(fence_queue));
    cover property ($fell(handle_fwd));
endmodule
bind mocd_top mocd_top_checker u_chk (.*);
`default_nettype wire

// ==== mocd_far_model.sv ====
// dispatcher and root thread model on the decoder's far side
`timescale 1ns/1ps
`default_nettype none
module mocd_far_model (
    input wire logic ref_clk, // clock
    input wire logic nrst, // reset, low
    input wire logic disp_req, // dispatch request
    input wire logic handle_fwd, // handle at thread
    input wire logic [3:0] ack_delay, // ack wait cycles
    input wire logic auto_deref, // thread may release
    output logic disp_ack, // ack pulse
    output logic deref_msg // release pulse
);
    logic [3:0] cnt;
    logic sent;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 4'h0;
            sent <= 1'b0;
            disp_ack <= 1'b0;
            deref_msg <= 1'b0;
        end else begin
            disp_ack <= disp_req && !disp_ack && cnt == ack_delay;
            cnt <= (disp_req && !disp_ack) ? cnt + 4'h1 : 4'h0;
            deref_msg <= handle_fwd && auto_deref && !sent;
            sent <= handle_fwd && (sent || auto_deref);
        end
    end
endmodule
`default_nettype wire

// ==== mocd_top_tb_top.sv ====
// self-checking bench for the media object command decoder
`timescale 1ns/1ps
`default_nettype none
module mocd_top_tb_top;
    import mocd_pkg::*;
    logic ref_clk = 1'b0, nrst = 1'b0, cmd_valid = 1'b0, spawn_root_msg = 1'b0;
    logic redispatch = 1'b0, thread_spawn_msg = 1'b0, auto_deref = 1'b0;
    logic [31:0] cmd_data = 32'h0;
    logic [7:0] state_sb_mask = 8'h5f;
    logic [3:0] ack_delay = 4'h0;
    logic cmd_ready, disp_ack, deref_msg, disp_req, disp_persist, disp_sb_use, disp_hs_any;
    logic disp_hs1, ind_fetch, handle_fwd, handle_deref, inline_valid, fence_queue, fence_entry;
    logic [5:0] disp_desc;
    logic [8:0] disp_sb_y, disp_sb_x;
    logic [3:0] disp_color;
    logic [7:0] disp_mask;
    logic [16:0] ind_len_bytes;
    logic [28:0] ind_start;
    logic [31:0] inline_data;
    logic [31:0] inl_q[$];
    int mismatches = 0, samples_checked = 0, deref_cnt = 0;
    ////////////////////////////////////////////////////////////////////////////////
    mocd_top dut (.*);
    mocd_far_model far (.ref_clk(ref_clk), .nrst(nrst), .disp_req(disp_req),
        .handle_fwd(handle_fwd), .ack_delay(ack_delay), .auto_deref(auto_deref),
        .disp_ack(disp_ack), .deref_msg(deref_msg));
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (inline_valid === 1'b1) inl_q.push_back(inline_data);
        if (handle_deref === 1'b1) deref_cnt++;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic fail_wait();
        mismatches++;
        $display("BAD wait expected done seen timeout");
        wrap_up();
    endtask
    // w: 0 waits on disp_req, 1 on cmd_ready
    task automatic wait_lvl(input logic w, input logic v);
        int i;
        for (i = 0; i < 80 && (w ? cmd_ready : disp_req) !== v; i++) tick(1);
        if ((w ? cmd_ready : disp_req) !== v) fail_wait();
    endtask
    task automatic send_dw(input logic [31:0] d);
        int i;
        cmd_valid = 1'b1;
        cmd_data = d;
        for (i = 0; i < 80; i++) begin
            @(posedge ref_clk);
            if (cmd_ready === 1'b1) break;
        end
        #1;
        if (i == 80) fail_wait();
    endtask
    // idle data toggles so a stale dword never looks valid
    task automatic idle();
        cmd_valid = 1'b0;
        cmd_data = ~cmd_data;
    endtask
    task automatic pulse(input logic [2:0] w);
        {spawn_root_msg, thread_spawn_msg, redispatch} = w;
        tick(1);
        {spawn_root_msg, thread_spawn_msg, redispatch} = 3'h0;
    endtask
    function automatic logic [31:0] fl(input logic c, s, b, input logic [1:0] h,
        input logic [16:0] l);
        return {c, 6'h0, s, 2'h0, b, 2'h0, h, l};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // indirect lengths stay 32-byte multiples, like the start offset
    // inline plus indirect stays far below 112 eight-dword units
    // no memory region is refilled, so no fetch cache flush is due
    task automatic run_obj(input logic [5:0] dsc, input logic [31:0] f, input logic [8:0] y, x,
        input logic [3:0] col, input logic [7:0] msk, input int n, input logic j, g);
        int k, base;
        inl_q.delete();
        send_dw({CMD_TYPE_PIPE, CMD_PIPE_MEDIA, CMD_OPC_MEDIA, SUBOPC_OBJECT, 16'(n + 4)});
        send_dw({26'h0, dsc} | (j ? 32'hc0 : 32'h0));
        send_dw(f | (j ? 32'h7ed80000 : 32'h0));
        send_dw(32'h00c0ffe0);
        send_dw({7'h0, y, 7'h0, x} | (j ? 32'hfe00fe00 : 32'h0));
        send_dw({12'h0, col, 8'h0, msk} | (j ? 32'hfff0ff00 : 32'h0));
        for (k = 0; k < n; k++) send_dw(32'hc0de0000 + k);
        idle();
        if (g) begin
            tick(8);
            cmp("req held", 0, disp_req);
            pulse(f[24] ? 3'h4 : 3'h2);
        end
        wait_lvl(0, 1);
        cmp("persist", 0, disp_persist);
        cmp("desc", dsc, disp_desc);
        cmp("sb use", f[21], disp_sb_use);
        if (f[21]) cmp("sb yx", {y, x}, {disp_sb_y, disp_sb_x});
        if (f[21]) cmp("color", col, disp_color);
        if (f[21]) cmp("mask", msk & state_sb_mask, disp_mask);
        cmp("hs any", f[18:17] == 2'h0, disp_hs_any);
        if (f[18:17] != 2'h0) cmp("hs1", f[18], disp_hs1);
        cmp("fetch", f[16:0] != 17'h0, ind_fetch);
        if (f[16:0] != 17'h0) cmp("len", f[16:0], ind_len_bytes);
        if (f[16:0] != 17'h0) cmp("start", 32'h00c0ffe0, ind_start);
        base = deref_cnt;
        wait_lvl(0, 0);
        tick(3);
        cmp("inline n", n, inl_q.size());
        for (k = 0; k < n && k < inl_q.size(); k++) cmp("inline", 32'hc0de0000 + k, inl_q[k]);
        cmp("fwd", f[31], handle_fwd);
        cmp("deref", base + !f[31], deref_cnt);
    endtask
    // the bench has no variable-length-decode mode to avoid
    task automatic send_prt(input logic [5:0] dsc, input logic c, fe, ft);
        int k;
        inl_q.delete();
        send_dw({CMD_TYPE_PIPE, CMD_PIPE_MEDIA, CMD_OPC_MEDIA, SUBOPC_PERSIST, 16'h0014});
        send_dw({26'h0, dsc});
        send_dw({c, 7'h0, fe, ft, 22'h0});
        send_dw(32'h0);
        for (k = 4; k < 16; k++) send_dw(32'hbeef0000 + k);
        idle();
        wait_lvl(0, 1);
        cmp("persist", 1, disp_persist);
        cmp("desc", dsc, disp_desc);
        wait_lvl(0, 0);
        tick(2);
        cmp("inline n", 12, inl_q.size());
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        repeat (12) @(posedge ref_clk);
        #1;
        cmp("reset", 0, {cmd_ready, disp_req, handle_fwd, inline_valid, fence_queue, fence_entry});
        nrst = 1'b1;
        wait_lvl(1, 1);
    endtask
    // the either-half case also asks for either slice upstream
    task automatic t_routes();
        int h;
        for (h = 0; h < 3; h++) begin
            ack_delay = 4'(h * 3);
            run_obj(6'(h * 21), fl(0, 0, h[0], 2'(2 - h), h[0] ? 17'h40 : 17'h0), 9'h1ff,
                9'h101, 4'(h + 7), 8'hf3, h, 0, 0);
        end
    endtask
    task automatic t_sync();
        run_obj(6'h05, fl(0, 1, 1, 2'h1, 17'h0), 9'h0, 9'h1ff, 4'hf, 8'hff, 3, 0, 1);
    endtask
    task automatic t_children();
        int b;
        run_obj(6'h11, fl(1, 0, 1, 2'h2, 17'h20), 9'h055, 9'h0aa, 4'h0, 8'h00, 4, 0, 0);
        b = deref_cnt;
        tick(8);
        cmp("held handle", 1, handle_fwd);
        auto_deref = 1'b1;
        tick(8);
        cmp("deref once", b + 1, deref_cnt);
        cmp("fwd clear", 0, handle_fwd);
    endtask
    // length at the 496 dword ceiling
    task automatic t_reserved();
        state_sb_mask = 8'hff;
        // foreign command: skipped by its length, never dispatched
        send_dw({CMD_TYPE_PIPE, CMD_PIPE_MEDIA, 3'h0, 8'h04, 16'h0001});
        send_dw(32'h0);
        send_dw(32'h0);
        idle();
        tick(4);
        cmp("skip", 2'b01, {disp_req, cmd_ready});
        run_obj(6'h3f, fl(0, 0, 1, 2'h1, 17'h7c0), 9'h1ff, 9'h1ff, 4'ha, 8'h81, 1, 1, 0);
    endtask
    task automatic t_fence_queue();
        send_prt(6'h2a, 0, 1, 0);
        cmp("fence q", 1, fence_queue);
        cmp("fence e", 0, fence_entry);
        run_obj(6'h01, fl(0, 0, 0, 2'h0, 17'h0), 9'h0, 9'h0, 4'h0, 8'h0, 1, 0, 1);
        cmp("fence q off", 0, fence_queue);
    endtask
    task automatic t_fence_entry();
        int b;
        b = deref_cnt;
        send_prt(6'h3f, 1, 1, 1);
        cmp("fence e", 1, fence_entry);
        cmp("blocked", 0, cmd_ready);
        pulse(3'h2);
        cmp("fence e off", 0, fence_entry);
        pulse(3'h1);
        cmp("fence again", 1, fence_entry);
        pulse(3'h2);
        tick(3);
        cmp("fence e off", 0, fence_entry);
        cmp("deref by msg", b + 1, deref_cnt);
    endtask
    initial begin
        t_reset();
        t_routes();
        t_sync();
        t_children();
        t_reserved();
        t_fence_queue();
        t_fence_entry();
        wrap_up();
    end
endmodule
`default_nettype wire
